// file: hdl/sd_regs_pkg.sv
// constants for the card host status and command register bank
package sd_regs_pkg;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] CMD_OFS = 8'h0C;
  localparam logic [7:0] PARAM_OFS = 8'h10;
  localparam logic [7:0] RESP_W0_OFS = 8'h14;
  localparam logic [7:0] RESP_W1_OFS = 8'h18;
  localparam logic [7:0] RESP_W2_OFS = 8'h1C;
  localparam logic [7:0] RESP_W3_OFS = 8'h20;
  localparam logic [7:0] RESP_TOP_OFS = 8'h24;
  localparam logic [7:0] DATA_OFS = 8'h28;
  localparam logic [7:0] BLKLEN_OFS = 8'h2C;
  localparam logic [7:0] BLKCNT_OFS = 8'h30;
  localparam logic [7:0] XFER_CTL_OFS = 8'h40;
  // status bit positions, then the go bit of the transfer control register
  localparam int B_DAT1B = 18;
  localparam int B_SLOTB_PEND = 17;
  localparam int B_SLOTB_ON = 16;
  localparam int B_TOUT = 15;
  localparam int B_BAE = 14;
  localparam int B_BUFRDY = 12;
  localparam int B_CMDL = 11;
  localparam int B_DAT1A = 10;
  localparam int B_SLOTA_PEND = 9;
  localparam int B_SLOTA_ON = 8;
  localparam int B_DAT0 = 7;
  localparam int B_TE_EN = 6;
  localparam int B_TE_P = 5;
  localparam int B_NORSP = 4;
  localparam int B_CMDDONE = 3;
  localparam int B_WCRC = 2;
  localparam int B_RCRC = 1;
  localparam int B_RSPCRC = 0;
  localparam int B_GO = 0;
  localparam logic [7:0] CMD_RESET = 8'h40;
  localparam logic [9:0] BLKLEN_RESET = 10'h000;
  localparam logic [13:0] BLKCNT_RESET = 14'h0001;
  localparam logic [31:0] PARAM_RESET = 32'h00000000;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] LINES_RESET = 4'hF;
endpackage

// file: hdl/sd_line_sync.sv
// two-stage synchroniser for card line levels
`timescale 1ns/1ps
module sd_line_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // sd_line_sync

// file: hdl/sd_host_status_cmd_regs.sv
// status, command, response and block geometry registers of the card host
// Functional notes
// - bit 18 shows slot B DAT1 level
// - slot B SDIO pending sets, write-1 clears
// - bit 16 enables slot B SDIO interrupts
// - slot A SDIO pending sets, write-1 clears
// - bit 8 enables slot A SDIO interrupts
// - bit 10 shows slot A DAT1 level
// - timeout flag sets, clears at transfer start
// - boot ack error flag in ack-check mode
// - bit 12 shows buffer ready
// - bit 11 shows command line level
// - bit 7 shows DAT0 level
// - transfer-end pending, write-1 clear, enable gated
// - no-response flag, clears at transfer start
// - command-done flag, clears at transfer start
// - write CRC error flag, clears at start
// - read CRC error flag, clears at start
// - response CRC error flag, clears at start
// - command byte keeps bit7 0, bit6 1
// - 136-bit response in five read registers
// - 10-bit block length; SDR50 uses 512
// - 14-bit block count, reset 1, 0 none
// - transfer go clears on end or error
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module sd_host_status_cmd_regs
  import sd_regs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slot_a_dat1_pin,
  input wire logic slot_b_dat1_pin,
  input wire logic cmd_line_pin,
  input wire logic dat0_line_pin,
  input wire logic boot_ack_check_mode,
  input wire logic buffer_ready,
  input wire logic ev_xfer_done,
  input wire logic ev_timeout,
  input wire logic ev_boot_ack_err,
  input wire logic ev_no_response,
  input wire logic ev_command_done,
  input wire logic ev_write_crc_err,
  input wire logic ev_read_crc_err,
  input wire logic ev_response_crc_err,
  input wire logic rsp_valid,
  input wire logic [135:0] rsp_bits,
  input wire logic [31:0] read_data,
  output logic transfer_go,
  output logic xfer_start,
  output logic [7:0] command_byte,
  output logic [31:0] command_parameter,
  output logic [9:0] block_length_field,
  output logic [13:0] block_count_field,
  output logic irq
);
  import sd_regs_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] lines_s;
  logic slot_a_dat1_level;
  logic slot_b_dat1_level;
  logic cmd_line_level;
  logic dat0_line_level;

  // idle card lines are pulled high, so the synchronisers reset to 1
  sd_line_sync #(.WIDTH(4), .RESET_VAL(LINES_RESET)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({slot_b_dat1_pin, slot_a_dat1_pin, cmd_line_pin, dat0_line_pin}),
    .sync_out(lines_s)
  );

  assign slot_b_dat1_level = lines_s[3];
  assign slot_a_dat1_level = lines_s[2];
  assign cmd_line_level = lines_s[1];
  assign dat0_line_level = lines_s[0];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic known_addr;
  logic wr_status;
  logic wr_cmd;
  logic wr_param;
  logic wr_blklen;
  logic wr_blkcnt;
  logic wr_ctl;

  assign pready = 1'b1;
  assign known_addr = (paddr == STATUS_OFS) || (paddr == CMD_OFS) || (paddr == PARAM_OFS)
    || (paddr == RESP_W0_OFS) || (paddr == RESP_W1_OFS) || (paddr == RESP_W2_OFS)
    || (paddr == RESP_W3_OFS) || (paddr == RESP_TOP_OFS) || (paddr == DATA_OFS)
    || (paddr == BLKLEN_OFS) || (paddr == BLKCNT_OFS) || (paddr == XFER_CTL_OFS);
  assign pslverr = psel && penable && !known_addr;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign wr_status = wr_en && (paddr == STATUS_OFS);
  assign wr_cmd = wr_en && (paddr == CMD_OFS);
  assign wr_param = wr_en && (paddr == PARAM_OFS);
  assign wr_blklen = wr_en && (paddr == BLKLEN_OFS);
  assign wr_blkcnt = wr_en && (paddr == BLKCNT_OFS);
  assign wr_ctl = wr_en && (paddr == XFER_CTL_OFS);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [5:0] cmd_index_q;
  logic [31:0] param_q;
  logic [9:0] blklen_q;
  logic [13:0] blkcnt_q;
  logic go_q;
  logic go_d;
  logic start_pulse;
  logic any_err;

  assign start_pulse = wr_ctl && pwdata[B_GO] && !go_q;
  assign any_err = ev_timeout || ev_boot_ack_err || ev_no_response || ev_write_crc_err
    || ev_read_crc_err || ev_response_crc_err;
  // a start request while busy is ignored; software waits for go to fall
  assign go_d = start_pulse ? 1'b1 :
    (wr_ctl && !pwdata[B_GO]) ? 1'b0 :
    (ev_xfer_done || any_err) ? 1'b0 : go_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_index_q <= CMD_RESET[5:0];
      param_q <= PARAM_RESET;
      blklen_q <= BLKLEN_RESET;
      blkcnt_q <= BLKCNT_RESET;
      go_q <= 1'b0;
    end
    else
    begin
      if (wr_cmd)
        cmd_index_q <= pwdata[5:0];
      if (wr_param)
        param_q <= pwdata;
      if (wr_blklen)
        blklen_q <= pwdata[9:0];
      if (wr_blkcnt)
        blkcnt_q <= pwdata[13:0];
      go_q <= go_d;
    end
  end

  assign command_byte = {2'b01, cmd_index_q};
  assign command_parameter = param_q;
  assign block_length_field = blklen_q;
  assign block_count_field = blkcnt_q;
  assign transfer_go = go_q;
  assign xfer_start = start_pulse;

  // ----------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------
  logic sdio_a_p_q;
  logic sdio_b_p_q;
  logic sdio_a_en_q;
  logic sdio_b_en_q;
  logic te_en_q;
  logic te_p_q;
  logic [6:0] err_q;
  logic [6:0] err_set;
  logic dat1a_prev_q;
  logic dat1b_prev_q;
  logic sdio_a_ev;
  logic sdio_b_ev;

  // card signals interrupt by pulling DAT1 low
  assign sdio_a_ev = sdio_a_en_q && dat1a_prev_q && !slot_a_dat1_level;
  assign sdio_b_ev = sdio_b_en_q && dat1b_prev_q && !slot_b_dat1_level;
  assign err_set = {ev_timeout, ev_boot_ack_err && boot_ack_check_mode, ev_no_response,
    ev_command_done, ev_write_crc_err, ev_read_crc_err, ev_response_crc_err};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sdio_a_p_q <= 1'b0;
      sdio_b_p_q <= 1'b0;
      sdio_a_en_q <= 1'b0;
      sdio_b_en_q <= 1'b0;
      te_en_q <= 1'b0;
      te_p_q <= 1'b0;
      err_q <= 7'h00;
      dat1a_prev_q <= 1'b1;
      dat1b_prev_q <= 1'b1;
    end
    else
    begin
      dat1a_prev_q <= slot_a_dat1_level;
      dat1b_prev_q <= slot_b_dat1_level;
      // set wins over a clear in the same cycle
      sdio_a_p_q <= sdio_a_ev || (sdio_a_p_q && !(wr_status && pwdata[B_SLOTA_PEND]));
      sdio_b_p_q <= sdio_b_ev || (sdio_b_p_q && !(wr_status && pwdata[B_SLOTB_PEND]));
      te_p_q <= ev_xfer_done || (te_p_q && !(wr_status && pwdata[B_TE_P]));
      err_q <= err_set | (start_pulse ? 7'h00 : err_q);
      if (wr_status)
      begin
        sdio_a_en_q <= pwdata[B_SLOTA_ON];
        sdio_b_en_q <= pwdata[B_SLOTB_ON];
        te_en_q <= pwdata[B_TE_EN];
      end
    end
  end

  assign irq = (te_p_q && te_en_q) || (sdio_a_p_q && sdio_a_en_q)
    || (sdio_b_p_q && sdio_b_en_q);

  // ----------------------------------------------------------------
  // response capture
  // ----------------------------------------------------------------
  logic [135:0] rsp_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsp_q <= 136'h0;
    else if (rsp_valid)
      rsp_q <= rsp_bits;
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [31:0] rdata_q;

  assign status_word = {13'h0000, slot_b_dat1_level, sdio_b_p_q, sdio_b_en_q,
    err_q[6], err_q[5], 1'b0, buffer_ready,
    cmd_line_level, slot_a_dat1_level, sdio_a_p_q, sdio_a_en_q,
    dat0_line_level, te_en_q, te_p_q, err_q[4:0]};

  always_comb
  begin
    unique case (paddr)
      STATUS_OFS: rd_word = status_word;
      CMD_OFS: rd_word = {24'h000000, command_byte};
      PARAM_OFS: rd_word = param_q;
      RESP_W0_OFS: rd_word = rsp_q[31:0];
      RESP_W1_OFS: rd_word = rsp_q[63:32];
      RESP_W2_OFS: rd_word = rsp_q[95:64];
      RESP_W3_OFS: rd_word = rsp_q[127:96];
      RESP_TOP_OFS: rd_word = {24'h000000, rsp_q[135:128]};
      DATA_OFS: rd_word = read_data;
      BLKLEN_OFS: rd_word = {22'h000000, blklen_q};
      BLKCNT_OFS: rd_word = {18'h00000, blkcnt_q};
      XFER_CTL_OFS: rd_word = {31'h00000000, go_q};
      default: rd_word = 32'h00000000;
    endcase
  end

  // data is captured in the setup cycle so prdata is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 32'h00000000;
    else if (rd_en)
      rdata_q <= rd_word;
  end

  assign prdata = rdata_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_start;
    start_pulse;
  endsequence

  // a card interrupt is a high-to-low step on DAT1 while the slot is enabled
  sequence s_slot_a_fall;
    slot_a_dat1_level ##1 (!slot_a_dat1_level && sdio_a_en_q);
  endsequence

  sequence s_slot_b_fall;
    slot_b_dat1_level ##1 (!slot_b_dat1_level && sdio_b_en_q);
  endsequence

  AST_CMD_FIXED: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd |=> command_byte == {2'b01, $past(pwdata[5:0])})
    else $error("command byte not stored with fixed prefix");
  AST_ERR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    s_start ##0 (err_set == 7'h00) |=> err_q == 7'h00)
    else $error("flags kept at start");
  AST_ERR_SET: assert property (@(posedge pclk) disable iff (!presetn)
    err_set != 7'h00 |=> (err_q & $past(err_set)) == $past(err_set))
    else $error("error flag not latched");
  AST_BAE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    ev_boot_ack_err && !boot_ack_check_mode && !err_q[5] |=> !err_q[5])
    else $error("boot ack flag set outside check mode");
  AST_TE_SET: assert property (@(posedge pclk) disable iff (!presetn)
    ev_xfer_done |=> te_p_q)
    else $error("transfer end not latched");
  AST_TE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    te_p_q && wr_status && pwdata[B_TE_P] && !ev_xfer_done |=> !te_p_q)
    else $error("transfer end not cleared");
  AST_SDIOA: assert property (@(posedge pclk) disable iff (!presetn)
    !sdio_a_en_q && !$past(sdio_a_p_q) && !sdio_a_p_q |=> !sdio_a_p_q || sdio_a_en_q)
    else $error("slot a pend while off");
  AST_SDIOA_SET: assert property (@(posedge pclk) disable iff (!presetn)
    s_slot_a_fall |=> sdio_a_p_q)
    else $error("slot a pend lost");
  AST_SDIOA_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    sdio_a_p_q && wr_status && pwdata[B_SLOTA_PEND] && !sdio_a_ev |=> !sdio_a_p_q)
    else $error("slot a pend not cleared");
  AST_SDIOB_SET: assert property (@(posedge pclk) disable iff (!presetn)
    s_slot_b_fall |=> sdio_b_p_q)
    else $error("slot b pend lost");
  AST_SDIOB_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    sdio_b_p_q && wr_status && pwdata[B_SLOTB_PEND] && !sdio_b_ev |=> !sdio_b_p_q)
    else $error("slot b pend not cleared");
  AST_SDIOB_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !sdio_b_en_q |=> !$rose(sdio_b_p_q))
    else $error("slot b pend while off");
  AST_GO_START: assert property (@(posedge pclk) disable iff (!presetn)
    s_start |=> go_q)
    else $error("go not set by start");
  AST_GO_END: assert property (@(posedge pclk) disable iff (!presetn)
    go_q && ev_xfer_done && !wr_ctl |=> !go_q)
    else $error("go stuck");
  AST_GO_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    go_q && any_err && !wr_ctl |=> !go_q)
    else $error("go stuck after error");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    ev_xfer_done && te_en_q && !wr_status |=> irq)
    else $error("irq missing after enabled transfer end");
  AST_BLKCNT: assert property (@(posedge pclk) disable iff (!presetn)
    wr_blkcnt |=> blkcnt_q == $past(pwdata[13:0]))
    else $error("block count not stored");
  AST_BLKLEN: assert property (@(posedge pclk) disable iff (!presetn)
    wr_blklen |=> blklen_q == $past(pwdata[9:0]))
    else $error("block length not stored");
  AST_RSP: assert property (@(posedge pclk) disable iff (!presetn)
    rsp_valid |=> rsp_q[135:128] == $past(rsp_bits[135:128]))
    else $error("rsp top lost");
  AST_LINES: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> {status_word[B_DAT1B], status_word[B_DAT1A], status_word[B_CMDL],
    status_word[B_DAT0]} == $past({slot_b_dat1_pin, slot_a_dat1_pin, cmd_line_pin, dat0_line_pin}, 2))
    else $error("line level not shown");
endmodule // sd_host_status_cmd_regs

// file: verif/sd_card_model.sv
// card side model: line levels and SDIO interrupt signalling on DAT1
`timescale 1ns/1ps
module sd_card_model (
  input wire logic sdio_req_a,
  input wire logic sdio_req_b,
  input wire logic cmd_lvl,
  input wire logic dat0_lvl,
  output logic slot_a_dat1_pin,
  output logic slot_b_dat1_pin,
  output logic cmd_line_pin,
  output logic dat0_line_pin
);
  // lines have pull-ups, so a released DAT1 reads 1
  assign cmd_line_pin = cmd_lvl;
  assign dat0_line_pin = dat0_lvl;
  initial
  begin
    slot_a_dat1_pin <= 1'b1;
    slot_b_dat1_pin <= 1'b1;
  end
  // interrupt signalled as DAT1 held low for two card clocks of 160 ns
  // non-blocking so a change on a clock edge never races the synchroniser
  always @(posedge sdio_req_a)
  begin
    slot_a_dat1_pin <= 1'b0;
    #320 slot_a_dat1_pin <= 1'b1;
  end
  always @(posedge sdio_req_b)
  begin
    slot_b_dat1_pin <= 1'b0;
    #320 slot_b_dat1_pin <= 1'b1;
  end
endmodule // sd_card_model

// file: verif/sd_host_status_cmd_regs_tb.sv
// self-checking bench for the card host register bank
`timescale 1ns/1ps
module sd_host_status_cmd_regs_tb;
  import sd_regs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, read_data = '0, rdata;
  logic pready, pslverr, serr, st, boot_mode = 0, buf_rdy = 0, rsp_valid = 0;
  logic [7:0] ev = '0;
  logic [135:0] rsp_bits = '0;
  logic req_a = 0, req_b = 0, cmd_lvl = 1, dat0_lvl = 1;
  logic pa, pb, pc, pd, transfer_go, xfer_start, irq;
  logic [7:0] command_byte;
  logic [31:0] command_parameter;
  logic [9:0] block_length_field;
  logic [13:0] block_count_field;
  int bad_count = 0, total_checks = 0;
  always #10 pclk = ~pclk;
  sd_card_model card (.sdio_req_a(req_a), .sdio_req_b(req_b), .cmd_lvl(cmd_lvl),
    .dat0_lvl(dat0_lvl), .slot_a_dat1_pin(pa), .slot_b_dat1_pin(pb), .cmd_line_pin(pc),
    .dat0_line_pin(pd));
  sd_host_status_cmd_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slot_a_dat1_pin(pa), .slot_b_dat1_pin(pb),
    .cmd_line_pin(pc), .dat0_line_pin(pd), .boot_ack_check_mode(boot_mode),
    .buffer_ready(buf_rdy), .ev_xfer_done(ev[0]), .ev_timeout(ev[1]),
    .ev_boot_ack_err(ev[2]), .ev_no_response(ev[3]), .ev_command_done(ev[4]),
    .ev_write_crc_err(ev[5]), .ev_read_crc_err(ev[6]), .ev_response_crc_err(ev[7]),
    .rsp_valid(rsp_valid), .rsp_bits(rsp_bits), .read_data(read_data),
    .transfer_go(transfer_go), .xfer_start(xfer_start), .command_byte(command_byte),
    .command_parameter(command_parameter), .block_length_field(block_length_field),
    .block_count_field(block_count_field), .irq(irq));
  // -----------------------------
  // checks and bus cycles
  // -----------------------------
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // master waits for pready with no assumed latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    st = xfer_start;
    psel <= 0;
    penable <= 0;
    // one more edge so callers see registers written at the access edge
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk($sformatf("reg %h", a), rdata, e);
  endtask
  task pulse(input int i);
    ev[i] <= 1;
    @(posedge pclk);
    ev[i] <= 0;
    @(posedge pclk);
  endtask
  task wirq();
    int n;
    for (n = 0; n < 100 && irq !== 1'b1; n++)
      @(posedge pclk);
    chk("irq wait", 32'(irq), 32'h1);
    repeat (24) @(posedge pclk);
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end
  // -----------------------------
  // tests
  // -----------------------------
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(STATUS_OFS, 32'h00040C80);
    rd(CMD_OFS, 32'h00000040);
    rd(PARAM_OFS, 32'h0);
    rd(BLKLEN_OFS, 32'h0);
    rd(BLKCNT_OFS, 32'h00000001);
    for (int i = 0; i < 5; i++)
      rd(RESP_W0_OFS + 8'(4 * i), 32'h0);
    rd(8'h3C, 32'h0);
    chk("slverr", 32'(serr), 32'h1);
    $display("test reset done");
    cmd_lvl <= 0;
    dat0_lvl <= 0;
    buf_rdy <= 1;
    repeat (5) @(posedge pclk);
    rd(STATUS_OFS, 32'h00041400);
    cmd_lvl <= 1;
    dat0_lvl <= 1;
    buf_rdy <= 0;
    repeat (5) @(posedge pclk);
    $display("test lines done");
    wr(STATUS_OFS, 32'h00000100);
    req_a <= 1;
    wirq();
    req_a <= 0;
    rd(STATUS_OFS, 32'h00040F80);
    chk("irq", 32'(irq), 32'h1);
    wr(STATUS_OFS, 32'h00000300);
    rd(STATUS_OFS, 32'h00040D80);
    chk("irq", 32'(irq), 32'h0);
    wr(STATUS_OFS, 32'h0);
    req_b <= 1;
    repeat (40) @(posedge pclk);
    req_b <= 0;
    rd(STATUS_OFS, 32'h00040C80);
    wr(STATUS_OFS, 32'h00010000);
    req_b <= 1;
    wirq();
    req_b <= 0;
    rd(STATUS_OFS, 32'h00070C80);
    wr(STATUS_OFS, 32'h00030000);
    rd(STATUS_OFS, 32'h00050C80);
    wr(STATUS_OFS, 32'h0);
    $display("test sdio done");
    pulse(0);
    rd(STATUS_OFS, 32'h00040CA0);
    chk("irq", 32'(irq), 32'h0);
    wr(STATUS_OFS, 32'h00000040);
    chk("irq", 32'(irq), 32'h1);
    wr(STATUS_OFS, 32'h00000060);
    rd(STATUS_OFS, 32'h00040CC0);
    wr(STATUS_OFS, 32'h0);
    $display("test xfer end done");
    pulse(2);
    rd(STATUS_OFS, 32'h00040C80);
    boot_mode <= 1;
    for (int i = 1; i < 8; i++)
      pulse(i);
    rd(STATUS_OFS, 32'h0004CC9F);
    wr(XFER_CTL_OFS, 32'h1);
    chk("start", 32'(st), 32'h1);
    chk("go", 32'(transfer_go), 32'h1);
    rd(XFER_CTL_OFS, 32'h1);
    rd(STATUS_OFS, 32'h00040C80);
    wr(XFER_CTL_OFS, 32'h1);
    chk("start", 32'(st), 32'h0);
    pulse(3);
    chk("go", 32'(transfer_go), 32'h0);
    wr(XFER_CTL_OFS, 32'h1);
    wr(XFER_CTL_OFS, 32'h0);
    rd(XFER_CTL_OFS, 32'h0);
    $display("test errors done");
    wr(PARAM_OFS, 32'hA5A55A5A);
    wr(CMD_OFS, 32'h000000FF);
    rd(CMD_OFS, 32'h0000007F);
    chk("cmd", 32'(command_byte), 32'h0000007F);
    chk("param", command_parameter, 32'hA5A55A5A);
    wr(CMD_OFS, 32'h00000080);
    rd(CMD_OFS, 32'h00000040);
    rsp_bits <= 136'hC3_44444444_33333333_22222222_11111111;
    rsp_valid <= 1;
    @(posedge pclk);
    rsp_valid <= 0;
    for (int i = 0; i < 4; i++)
      rd(RESP_W0_OFS + 8'(4 * i), {4{8'(8'h11 * (i + 1))}});
    rd(RESP_TOP_OFS, 32'h000000C3);
    $display("test command done");
    wr(BLKLEN_OFS, 32'hFFFFFFFF);
    rd(BLKLEN_OFS, 32'h000003FF);
    chk("blklen", 32'(block_length_field), 32'h000003FF);
    wr(BLKCNT_OFS, 32'hFFFFFFFF);
    rd(BLKCNT_OFS, 32'h00003FFF);
    wr(BLKCNT_OFS, 32'h0);
    chk("blkcnt", 32'(block_count_field), 32'h0);
    read_data <= 32'h12345678;
    rd(DATA_OFS, 32'h12345678);
    $display("test geometry done");
    end_sim();
  end
endmodule // sd_host_status_cmd_regs_tb
